/* rtl/pot_cmd_pkg.sv */
// constants, types and command decoding for the serial potentiometer controller
// Notes on behaviour
// - receive-only port: select, data, clock; no readback
// - shift data in on falling clock edges
// - frame is command byte then data byte
// - act on complete frame immediately, no trigger
// - power-on loads tap register with midscale
// - decode command byte; data used only by set_tap
// - pump on by default; commands switch it
// - set_tap stores data byte, moves wiper
// - zero code near low end, full near high
// - leave_shutdown reconnects all, wiper to tap
// - shutdown commands leave pump state alone
// - open_high_keep_tap opens high, wiper at tap
// - set_tap ignored while shutdown is active
// - forced variants drive fixed code, keep tap
// - clearing shutdown restores terminal and tap
// - restore during shutdown ends it, wiper mid
// - restore_defaults returns power-on state
// - open_high_tap_full forces full-scale code
// - open_low variants mirror open_high ones
// - open_wiper opens wiper, keeps internal tap
package pot_cmd_pkg;

  // frame geometry
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // wiper codes
  localparam logic [7:0] TAP_ZERO = 8'h00;
  localparam logic [7:0] TAP_MID = 8'h80;
  localparam logic [7:0] TAP_FULL = 8'hff;

  // command byte codes and shutdown groups (upper six bits)
  localparam logic [7:0] CODE_SET_TAP = 8'h00;
  localparam logic [7:0] CODE_LEAVE = 8'h80;
  localparam logic [7:0] CODE_PUMP_OFF = 8'ha0;
  localparam logic [7:0] CODE_PUMP_ON = 8'ha1;
  localparam logic [7:0] CODE_RESTORE = 8'hc0;
  localparam logic [5:0] GRP_OPEN_HIGH = 6'h24;
  localparam logic [5:0] GRP_OPEN_LOW = 6'h22;
  localparam logic [5:0] GRP_OPEN_WIPER = 6'h21;

  // wiper forcing selected by the two low command bits
  localparam logic [1:0] FORCE_KEEP = 2'h0;
  localparam logic [1:0] FORCE_ZERO = 2'h1;
  localparam logic [1:0] FORCE_MID = 2'h2;
  localparam logic [1:0] FORCE_FULL = 2'h3;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } frame_type;

  typedef struct packed {
    logic high;
    logic low;
    logic wiper;
  } terms_type;

  typedef enum logic [8:0] {
    CMD_NONE = 9'h001,
    CMD_SET_TAP = 9'h002,
    CMD_LEAVE = 9'h004,
    CMD_OPEN_HIGH = 9'h008,
    CMD_OPEN_LOW = 9'h010,
    CMD_OPEN_WIPER = 9'h020,
    CMD_PUMP_OFF = 9'h040,
    CMD_PUMP_ON = 9'h080,
    CMD_RESTORE = 9'h100
  } cmd_type;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_HIGH = 4'h2,
    ST_LOW = 4'h4,
    ST_WIPER = 4'h8
  } open_state_type;

  // command byte to command kind; unlisted codes are ignored
  function automatic cmd_type decodeCmd(input logic [7:0] c);
    if (c == CODE_SET_TAP) return CMD_SET_TAP;
    if (c == CODE_LEAVE) return CMD_LEAVE;
    if (c == CODE_PUMP_OFF) return CMD_PUMP_OFF;
    if (c == CODE_PUMP_ON) return CMD_PUMP_ON;
    if (c == CODE_RESTORE) return CMD_RESTORE;
    if (c[7:2] == GRP_OPEN_HIGH) return CMD_OPEN_HIGH;
    if (c[7:2] == GRP_OPEN_LOW) return CMD_OPEN_LOW;
    if (c[7:2] == GRP_OPEN_WIPER) return CMD_OPEN_WIPER;
    return CMD_NONE;
  endfunction : decodeCmd

  // wiper code seen at the resistor for a forcing mode
  function automatic logic [7:0] forcedCode(input logic [1:0] f, input logic [7:0] tap);
    unique case (f)
      FORCE_ZERO: return TAP_ZERO;
      FORCE_MID: return TAP_MID;
      FORCE_FULL: return TAP_FULL;
      default: return tap;
    endcase
  endfunction : forcedCode

endpackage : pot_cmd_pkg

/* rtl/pot_sync3.sv */
// three-stage synchroniser for a level crossing into the core clock
`timescale 1ns/1ps
`default_nettype none
module pot_sync3 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic stage2_q,
  output logic stage3_q
);
  logic stage1_q;

  // stage1 feeds stage2 only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end else begin
      stage1_q <= d;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end
endmodule : pot_sync3
`default_nettype wire

/* rtl/pot_link_shifter.sv */
// serial-clock side: shifts in frames and hands complete ones over by toggle
`timescale 1ns/1ps
`default_nettype none
module pot_link_shifter (
  input wire logic sclk,
  input wire logic rst_b,
  input wire logic selB,
  input wire logic din,
  output var pot_cmd_pkg::frame_type frameWord_q,
  output logic frameToggle_q
);
  logic frameRst_b;
  logic lastBit;
  logic [4:0] bitCount_q;
  logic [14:0] shift_q;

  // select high clears a partial frame
  assign frameRst_b = rst_b & ~selB;
  assign lastBit = (bitCount_q == (pot_cmd_pkg::FRAME_BITS - 5'h01));

  // falling-edge shifting, msb first, stops after a full frame
  always_ff @(negedge sclk or negedge frameRst_b) begin
    if (!frameRst_b) begin
      bitCount_q <= 5'h00;
      shift_q <= 15'h0000;
    end else if (bitCount_q != pot_cmd_pkg::FRAME_BITS) begin
      bitCount_q <= bitCount_q + 5'h01;
      shift_q <= {shift_q[13:0], din};
    end
  end

  // complete frame held stable and flagged by toggle
  always_ff @(negedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      frameWord_q <= '0;
      frameToggle_q <= 1'b0;
    end else if (!selB && lastBit) begin
      frameWord_q <= {shift_q, din};
      frameToggle_q <= ~frameToggle_q;
    end
  end

  AST_BIT_LIMIT: assert property (@(negedge sclk) disable iff (!frameRst_b)
    bitCount_q <= pot_cmd_pkg::FRAME_BITS)
    else $error("bit counter ran past one frame");
endmodule : pot_link_shifter
`default_nettype wire

/* rtl/spi_pot_command_decoder.sv */
// serial command decoder for a 256-tap potentiometer: wiper, shutdown, pump
`timescale 1ns/1ps
`default_nettype none
module spi_pot_command_decoder (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic selB,
  input wire logic din,
  output logic [7:0] tapCode_q,
  output logic [7:0] wiperCode_q,
  output var pot_cmd_pkg::terms_type openTerms_q,
  output logic pumpEnable_q,
  output logic shutdownActive_q,
  output logic frameStrobe_q,
  output logic unknownCmd_q
);

  // link-side frame and its handover toggle
  pot_cmd_pkg::frame_type linkFrame;
  logic linkToggle;

  // synchronised toggle and the last one acted upon
  logic tgS2;
  logic tgS3;
  logic acceptedTog_q;
  logic accept;

  // decoded command and its parts
  pot_cmd_pkg::cmd_type cmdDec;
  logic [7:0] frameCmd;
  logic [7:0] frameData;

  // control state
  pot_cmd_pkg::open_state_type state_q;
  pot_cmd_pkg::open_state_type state_d;
  logic [1:0] force_q;
  logic [1:0] force_d;
  logic [7:0] tap_d;
  logic [7:0] wiper_d;
  logic pump_d;
  pot_cmd_pkg::terms_type terms_d;
  logic setTapOk;
  logic anyFrame_q;
  logic pumpCmd;

  // receive-only link: no output pin exists
  pot_link_shifter linkSide (
    .sclk(sclk),
    .rst_b(rst_b),
    .selB(selB),
    .din(din),
    .frameWord_q(linkFrame),
    .frameToggle_q(linkToggle)
  );

  // frame event into the core clock
  pot_sync3 toggleSync (
    .clk(core_clk),
    .rst_b(rst_b),
    .d(linkToggle),
    .stage2_q(tgS2),
    .stage3_q(tgS3)
  );

  // new frame once stages 2 and 3 agree on a fresh toggle
  assign accept = (tgS2 == tgS3) && (tgS3 != acceptedTog_q);

  // frame word is stable for many link cycles after the toggle
  assign frameCmd = linkFrame.cmd;
  assign frameData = linkFrame.data;
  assign cmdDec = pot_cmd_pkg::decodeCmd(frameCmd);

  // set_tap is locked out during any shutdown
  assign setTapOk = accept && (cmdDec == pot_cmd_pkg::CMD_SET_TAP)
    && (state_q == pot_cmd_pkg::ST_RUN);

  // shutdown state selection
  always_comb begin
    state_d = state_q;
    if (accept) begin
      unique case (cmdDec)
        pot_cmd_pkg::CMD_LEAVE: state_d = pot_cmd_pkg::ST_RUN;
        pot_cmd_pkg::CMD_RESTORE: state_d = pot_cmd_pkg::ST_RUN;
        pot_cmd_pkg::CMD_OPEN_HIGH: state_d = pot_cmd_pkg::ST_HIGH;
        pot_cmd_pkg::CMD_OPEN_LOW: state_d = pot_cmd_pkg::ST_LOW;
        pot_cmd_pkg::CMD_OPEN_WIPER: state_d = pot_cmd_pkg::ST_WIPER;
        pot_cmd_pkg::CMD_SET_TAP: state_d = state_q;
        pot_cmd_pkg::CMD_PUMP_OFF: state_d = state_q;
        pot_cmd_pkg::CMD_PUMP_ON: state_d = state_q;
        pot_cmd_pkg::CMD_NONE: state_d = state_q;
      endcase
    end
  end

  // wiper forcing mode: low command bits on open_high and open_low
  assign force_d = !accept ? force_q
    : ((cmdDec == pot_cmd_pkg::CMD_OPEN_HIGH) || (cmdDec == pot_cmd_pkg::CMD_OPEN_LOW))
      ? frameCmd[1:0]
    : ((cmdDec == pot_cmd_pkg::CMD_OPEN_WIPER) || (cmdDec == pot_cmd_pkg::CMD_LEAVE)
      || (cmdDec == pot_cmd_pkg::CMD_RESTORE)) ? pot_cmd_pkg::FORCE_KEEP
    : force_q;

  // tap register: data byte on set_tap, midscale on restore
  assign tap_d = setTapOk ? frameData
    : (accept && (cmdDec == pot_cmd_pkg::CMD_RESTORE)) ? pot_cmd_pkg::TAP_MID
    : tapCode_q;

  // pump follows only its own commands and restore
  assign pump_d = !accept ? pumpEnable_q
    : (cmdDec == pot_cmd_pkg::CMD_PUMP_OFF) ? 1'b0
    : (cmdDec == pot_cmd_pkg::CMD_PUMP_ON) ? 1'b1
    : (cmdDec == pot_cmd_pkg::CMD_RESTORE) ? 1'b1
    : pumpEnable_q;

  // a frame that may legally move the pump
  assign pumpCmd = accept && ((cmdDec == pot_cmd_pkg::CMD_PUMP_OFF) || (cmdDec == pot_cmd_pkg::CMD_PUMP_ON)
    || (cmdDec == pot_cmd_pkg::CMD_RESTORE));

  // wiper code: tap register unless a forcing mode holds
  assign wiper_d = pot_cmd_pkg::forcedCode(force_d, tap_d);

  // which terminal is open, one driver for the whole struct
  assign terms_d = {
    (state_d == pot_cmd_pkg::ST_HIGH),
    (state_d == pot_cmd_pkg::ST_LOW),
    (state_d == pot_cmd_pkg::ST_WIPER)
  };

  // handshake bookkeeping
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acceptedTog_q <= 1'b0;
      anyFrame_q <= 1'b0;
    end else if (accept) begin
      acceptedTog_q <= tgS3;
      anyFrame_q <= 1'b1;
    end
  end

  // shutdown state and forcing mode
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= pot_cmd_pkg::ST_RUN;
      force_q <= pot_cmd_pkg::FORCE_KEEP;
    end else begin
      state_q <= state_d;
      force_q <= force_d;
    end
  end

  // tap, wiper and pump, midscale and pump on at power-up
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tapCode_q <= pot_cmd_pkg::TAP_MID;
      wiperCode_q <= pot_cmd_pkg::TAP_MID;
      pumpEnable_q <= 1'b1;
    end else begin
      tapCode_q <= tap_d;
      wiperCode_q <= wiper_d;
      pumpEnable_q <= pump_d;
    end
  end

  // terminal and status outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      openTerms_q <= '0;
      shutdownActive_q <= 1'b0;
      frameStrobe_q <= 1'b0;
      unknownCmd_q <= 1'b0;
    end else begin
      openTerms_q <= terms_d;
      shutdownActive_q <= (state_d != pot_cmd_pkg::ST_RUN);
      frameStrobe_q <= accept;
      unknownCmd_q <= accept && (cmdDec == pot_cmd_pkg::CMD_NONE);
    end
  end

  // checks, all on the core clock
  default clocking coreCb @(posedge core_clk);
  endclocking

  default disable iff (!rst_b);

  // a frame of a given kind taken this cycle
  sequence seqCmd(pot_cmd_pkg::cmd_type c);
    accept && (cmdDec == c);
  endsequence

  // a shutdown command taken with a given forcing mode
  sequence seqOpenForced(logic [1:0] f);
    accept && ((cmdDec == pot_cmd_pkg::CMD_OPEN_HIGH)
      || (cmdDec == pot_cmd_pkg::CMD_OPEN_LOW)) && (frameCmd[1:0] == f);
  endsequence

  // a toggle change has reached stage 2
  sequence seqToggleArrives;
    tgS2 != acceptedTog_q;
  endsequence

  AST_POWER_ON: assert property (
    !anyFrame_q |-> (tapCode_q == pot_cmd_pkg::TAP_MID)
      && (wiperCode_q == pot_cmd_pkg::TAP_MID) && pumpEnable_q && !shutdownActive_q)
    else $error("power-up state is not midscale with pump on");

  AST_FRAME_LATENCY: assert property (
    seqToggleArrives |-> ##[1:2] frameStrobe_q)
    else $error("completed frame not acted upon in time");

  AST_STROBE_SINGLE: assert property (
    frameStrobe_q |=> !frameStrobe_q)
    else $error("one frame acted upon twice");

  AST_SET_TAP: assert property (
    seqCmd(pot_cmd_pkg::CMD_SET_TAP) ##0 !shutdownActive_q
      |=> (tapCode_q == $past(frameData)) && (wiperCode_q == tapCode_q))
    else $error("set_tap did not move tap and wiper");

  AST_TAP_LOCKED: assert property (
    seqCmd(pot_cmd_pkg::CMD_SET_TAP) ##0 shutdownActive_q
      |=> $stable(tapCode_q) && shutdownActive_q)
    else $error("tap written during shutdown");

  AST_WIPER_FOLLOWS: assert property (
    !shutdownActive_q |-> (wiperCode_q == tapCode_q))
    else $error("wiper differs from tap outside shutdown");

  AST_HIGH_KEEP: assert property (
    seqCmd(pot_cmd_pkg::CMD_OPEN_HIGH) ##0 (frameCmd[1:0] == pot_cmd_pkg::FORCE_KEEP)
      |=> openTerms_q.high && !openTerms_q.low && (wiperCode_q == tapCode_q))
    else $error("open high keeping tap misbehaved");

  AST_FORCE_ZERO: assert property (
    seqOpenForced(pot_cmd_pkg::FORCE_ZERO)
      |=> (wiperCode_q == pot_cmd_pkg::TAP_ZERO) && $stable(tapCode_q))
    else $error("zero forcing wrong");

  AST_FORCE_MID: assert property (
    seqOpenForced(pot_cmd_pkg::FORCE_MID)
      |=> (wiperCode_q == pot_cmd_pkg::TAP_MID) && $stable(tapCode_q))
    else $error("mid forcing wrong");

  AST_FORCE_FULL: assert property (
    seqOpenForced(pot_cmd_pkg::FORCE_FULL)
      |=> (wiperCode_q == pot_cmd_pkg::TAP_FULL) && $stable(tapCode_q))
    else $error("full forcing wrong");

  AST_OPEN_LOW: assert property (
    seqCmd(pot_cmd_pkg::CMD_OPEN_LOW) |=> openTerms_q.low && !openTerms_q.high
      && !openTerms_q.wiper && shutdownActive_q)
    else $error("open low did not open only the low end");

  AST_OPEN_WIPER: assert property (
    seqCmd(pot_cmd_pkg::CMD_OPEN_WIPER) |=> openTerms_q.wiper
      && (wiperCode_q == tapCode_q))
    else $error("open wiper lost the tap");

  AST_LEAVE: assert property (
    seqCmd(pot_cmd_pkg::CMD_LEAVE) |=> (openTerms_q == '0)
      && !shutdownActive_q && (wiperCode_q == tapCode_q))
    else $error("leave_shutdown did not restore");

  AST_RESTORE: assert property (
    seqCmd(pot_cmd_pkg::CMD_RESTORE) |=> (tapCode_q == pot_cmd_pkg::TAP_MID)
      && (wiperCode_q == pot_cmd_pkg::TAP_MID) && pumpEnable_q
      && !shutdownActive_q && (openTerms_q == '0))
    else $error("restore did not reach power-up state");

  AST_PUMP_OFF: assert property (
    seqCmd(pot_cmd_pkg::CMD_PUMP_OFF) |=> !pumpEnable_q)
    else $error("pump not disabled");

  AST_PUMP_ON: assert property (
    seqCmd(pot_cmd_pkg::CMD_PUMP_ON) |=> pumpEnable_q)
    else $error("pump not enabled");

  AST_PUMP_KEPT: assert property (
    (seqCmd(pot_cmd_pkg::CMD_LEAVE) or seqCmd(pot_cmd_pkg::CMD_OPEN_HIGH)
      or seqCmd(pot_cmd_pkg::CMD_OPEN_LOW) or seqCmd(pot_cmd_pkg::CMD_OPEN_WIPER))
      |=> $stable(pumpEnable_q))
    else $error("shutdown command changed the pump");

  AST_UNKNOWN_PULSE: assert property (
    seqCmd(pot_cmd_pkg::CMD_NONE) |=> unknownCmd_q && frameStrobe_q)
    else $error("unlisted command byte not flagged");

  AST_UNKNOWN_KEEPS: assert property (
    seqCmd(pot_cmd_pkg::CMD_NONE) |=> $stable(tapCode_q) && $stable(wiperCode_q)
      && $stable(openTerms_q) && $stable(pumpEnable_q))
    else $error("unlisted command byte changed the device");

  AST_UNKNOWN_CAUSE: assert property (
    unknownCmd_q |-> frameStrobe_q)
    else $error("unlisted command flag without a frame");

  AST_STROBE_CAUSE: assert property (
    frameStrobe_q |-> $past(accept))
    else $error("frame strobe without an accepted frame");

  AST_QUIET_HOLD: assert property (
    !accept |=> $stable(tapCode_q) && $stable(wiperCode_q) && $stable(openTerms_q)
      && $stable(pumpEnable_q) && $stable(shutdownActive_q))
    else $error("outputs moved without a frame");

  AST_ONE_OPEN: assert property (
    $onehot0(openTerms_q))
    else $error("more than one terminal open");

  AST_SHUTDOWN_FLAG: assert property (
    shutdownActive_q == (openTerms_q != '0))
    else $error("shutdown flag and open terminals disagree");

  AST_OPEN_HIGH: assert property (
    seqCmd(pot_cmd_pkg::CMD_OPEN_HIGH) |=> openTerms_q.high && !openTerms_q.low
      && !openTerms_q.wiper && shutdownActive_q)
    else $error("open high did not open only the high end");

  AST_LOW_KEEP: assert property (
    seqCmd(pot_cmd_pkg::CMD_OPEN_LOW) ##0 (frameCmd[1:0] == pot_cmd_pkg::FORCE_KEEP)
      |=> wiperCode_q == tapCode_q)
    else $error("open low keeping tap moved the wiper");

  AST_LEAVE_TAP: assert property (
    seqCmd(pot_cmd_pkg::CMD_LEAVE) |=> $stable(tapCode_q))
    else $error("leave_shutdown changed the tap register");

  AST_WIPER_ONLY: assert property (
    seqCmd(pot_cmd_pkg::CMD_OPEN_WIPER) |=> !openTerms_q.high && !openTerms_q.low
      && shutdownActive_q)
    else $error("open wiper opened another terminal");

  AST_PUMP_IDLE: assert property (
    !pumpCmd |=> $stable(pumpEnable_q))
    else $error("pump moved without its own command");

  AST_RESTORE_SHUT: assert property (
    seqCmd(pot_cmd_pkg::CMD_RESTORE) ##0 shutdownActive_q
      |=> !shutdownActive_q && (wiperCode_q == pot_cmd_pkg::TAP_MID))
    else $error("restore did not end shutdown at midscale");

endmodule : spi_pot_command_decoder
`default_nettype wire

/* dv/pot_host_model.sv */
// serial host model: drives select, link clock and data frames
`timescale 1ns/1ps
`default_nettype none
module pot_host_model (
  output logic sclk,
  output logic selB,
  output logic din
);
  // idle: select high, link clock parked high between frames
  initial begin
    sclk = 1'b1;
    selB = 1'b1;
    din = 1'b0;
  end

  // one frame, msb first, 160 ns link period; nbits below 16 aborts it
  task automatic sendFrame(input logic [7:0] cmd, input logic [7:0] data, input int nbits);
    logic [15:0] word;
    word = {cmd, data}; // command byte leads, then data byte
    #23 selB = 1'b0; // odd offset keeps link phase apart from core clock
    for (int i = 15; i >= 16 - nbits; i--) begin
      din = word[i];
      #80 sclk = 1'b0; // device takes the bit on this edge
      #80 sclk = 1'b1;
    end
    selB = 1'b1; // select held low for the whole frame, or aborted early
    din = ~din; // released line shows no stale bit
    #100;
  endtask : sendFrame
endmodule : pot_host_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the serial potentiometer command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk;
  logic rst_b;
  logic sclk;
  logic selB;
  logic din;
  logic [7:0] tapCode_q;
  logic [7:0] wiperCode_q;
  pot_cmd_pkg::terms_type openTerms_q;
  logic pumpEnable_q;
  logic shutdownActive_q;
  logic frameStrobe_q;
  logic unknownCmd_q;
  int fail_count = 0;
  int check_count = 0;
  int strobeCount = 0;
  int unknownCount = 0;
  logic [7:0] groups [3] = '{8'h90, 8'h88, 8'h84};

  spi_pot_command_decoder spi_pot_command_decoder_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .selB(selB),
    .din(din),
    .tapCode_q(tapCode_q),
    .wiperCode_q(wiperCode_q),
    .openTerms_q(openTerms_q),
    .pumpEnable_q(pumpEnable_q),
    .shutdownActive_q(shutdownActive_q),
    .frameStrobe_q(frameStrobe_q),
    .unknownCmd_q(unknownCmd_q)
  );

  pot_host_model pot_host_model_i (
    .sclk(sclk),
    .selB(selB),
    .din(din)
  );

  // 100 MHz core clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // count one-cycle pulses mid-cycle; a stuck pulse inflates the count
  always @(negedge core_clk) begin
    if (frameStrobe_q === 1'b1) strobeCount++;
    if (unknownCmd_q === 1'b1) unknownCount++;
  end

  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // compare every settled output against the expected device state
  task automatic expectState(input logic [7:0] tap, input logic [7:0] wip, input logic [2:0] terms,
                             input logic pump, input logic sd);
    chk("tapCode", tap, tapCode_q);
    chk("wiperCode", wip, wiperCode_q);
    chk("openTerms", {5'h00, terms}, {5'h00, openTerms_q});
    chk("pumpEnable", {7'h00, pump}, {7'h00, pumpEnable_q});
    chk("shutdownActive", {7'h00, sd}, {7'h00, shutdownActive_q});
  endtask : expectState

  // full frame, then exactly one strobe and the expected unknown pulses
  task automatic send(input logic [7:0] cmd, input logic [7:0] data, input logic expUnk);
    int s0;
    int u0;
    int n;
    s0 = strobeCount;
    u0 = unknownCount;
    pot_host_model_i.sendFrame(cmd, data, 16);
    n = 0;
    while (strobeCount == s0 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if (strobeCount == s0) begin
      fail_count++;
      $display("mismatch frameStrobe expected pulse seen none");
      stop_test();
    end else begin
      repeat (4) @(negedge core_clk);
      chk("strobeCount", 8'(s0 + 1), 8'(strobeCount));
      chk("unknownCount", 8'(u0 + int'(expUnk)), 8'(unknownCount));
    end
  endtask : send

  // wiper seen in a shutdown: forced code or the stored tap
  function automatic logic [7:0] shutWiper(input logic [7:0] cmd, input logic [7:0] tap);
    if (cmd[2] === 1'b1 || cmd[1:0] === 2'h0) return tap;
    return (cmd[1:0] === 2'h1) ? 8'h00 : (cmd[1:0] === 2'h2) ? 8'h80 : 8'hff;
  endfunction : shutWiper

  initial begin
    int base;
    logic [7:0] cmd;
    rst_b = 1'b0;
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    expectState(8'h80, 8'h80, 3'h0, 1'b1, 1'b0);
    send(8'h00, 8'h3c, 1'b0);
    expectState(8'h3c, 8'h3c, 3'h0, 1'b1, 1'b0);
    send(8'h00, 8'h00, 1'b0);
    expectState(8'h00, 8'h00, 3'h0, 1'b1, 1'b0);
    send(8'h00, 8'hff, 1'b0);
    expectState(8'hff, 8'hff, 3'h0, 1'b1, 1'b0);
    // two frames with minimum select gap
    base = strobeCount;
    pot_host_model_i.sendFrame(8'h00, 8'h11, 16);
    pot_host_model_i.sendFrame(8'h00, 8'h22, 16);
    repeat (10) @(negedge core_clk);
    chk("strobeCount", 8'(base + 2), 8'(strobeCount));
    expectState(8'h22, 8'h22, 3'h0, 1'b1, 1'b0);
    // frame cut one bit short is dropped
    pot_host_model_i.sendFrame(8'h00, 8'h55, 15);
    repeat (20) @(negedge core_clk);
    chk("strobeCount", 8'(base + 2), 8'(strobeCount));
    expectState(8'h22, 8'h22, 3'h0, 1'b1, 1'b0);
    send(8'h55, 8'h12, 1'b1);
    expectState(8'h22, 8'h22, 3'h0, 1'b1, 1'b0);
    send(8'ha0, 8'h00, 1'b0);
    expectState(8'h22, 8'h22, 3'h0, 1'b0, 1'b0);
    // every shutdown code: enter, refuse a tap write, leave
    for (int i = 0; i < 12; i++) begin
      cmd = groups[i / 4] + 8'(i % 4);
      send(cmd, 8'h5a, 1'b0);
      expectState(8'h22, shutWiper(cmd, 8'h22), cmd[4:2], 1'b0, 1'b1);
      send(8'h00, 8'h77, 1'b0);
      expectState(8'h22, shutWiper(cmd, 8'h22), cmd[4:2], 1'b0, 1'b1);
      send(8'h80, 8'h00, 1'b0);
      expectState(8'h22, 8'h22, 3'h0, 1'b0, 1'b0);
    end
    send(8'ha1, 8'h00, 1'b0);
    expectState(8'h22, 8'h22, 3'h0, 1'b1, 1'b0);
    // restore while shut down with pump off
    send(8'h00, 8'h3c, 1'b0);
    send(8'h91, 8'h00, 1'b0);
    send(8'ha0, 8'h00, 1'b0);
    expectState(8'h3c, 8'h00, 3'h4, 1'b0, 1'b1);
    send(8'hc0, 8'h00, 1'b0);
    expectState(8'h80, 8'h80, 3'h0, 1'b1, 1'b0);
    // second power-on reset mid-run
    send(8'h00, 8'h44, 1'b0);
    expectState(8'h44, 8'h44, 3'h0, 1'b1, 1'b0);
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    expectState(8'h80, 8'h80, 3'h0, 1'b1, 1'b0);
    rst_b = 1'b1;
    repeat (2) @(negedge core_clk);
    expectState(8'h80, 8'h80, 3'h0, 1'b1, 1'b0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
